/* sar_adc_host.sv */
// Host end: trigger, shift clock burst, capture and result FIFO
`timescale 1ns/1ps
`include "sar_defines.svh"
module sar_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Fill side
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	// Drain side
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;
	assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data = mem[rd_reg];

	always_ff @(posedge i_clock)
	begin
		if (push)
		begin
			mem[wr_reg] <= i_in_data;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop)
			begin
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sar_fifo

module sar_adc_host (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Static configuration
	input wire logic i_self_clocked,
	input wire logic i_sel_upper,
	input wire logic i_sel_lower,
	input wire logic [7:0] i_msb_wait,
	// Conversion request
	input wire logic i_start,
	output logic o_start_ready,
	output logic o_busy,
	output logic o_frame_err,
	// Result stream
	output logic o_word_valid,
	input wire logic i_word_ready,
	output logic [15:0] o_word_data,
	// Link to converter
	sar_link_if.host link
);
	import sar_pkg::*;

	sar_host_state_t state_reg;
	logic [7:0] cnt_reg;
	logic [3:0] div_reg;
	logic [5:0] half_reg;
	logic sclk_reg;
	logic trig_reg;
	logic self_reg;
	logic sel_up_reg;
	logic sel_lo_reg;
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	logic [1:0] sync3_reg;
	logic [`SAR_CAPTURE_LAG-1:0] rise_pipe_reg;
	logic [17:0] cap_reg;
	logic [4:0] bits_reg;
	logic err_reg;
	logic [5:0] halves;
	logic [4:0] bits_want;
	logic cap_strobe;
	logic frame_ok;
	logic fifo_in_ready;

	assign halves = self_reg ? `SAR_SELF_HALVES : `SAR_ECHO_HALVES;
	assign bits_want = self_reg ? `SAR_SELF_BITS : `SAR_ECHO_BITS;

	// Bit 0 serial data, bit 1 echoed clock
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			sync1_reg <= 2'h0;
			sync2_reg <= 2'h0;
			sync3_reg <= 2'h0;
		end
		else
		begin
			sync1_reg <= {link.echoed_clock_out, link.serial_data};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_reg <= SAR_HOST_IDLE;
			cnt_reg <= 8'h00;
			div_reg <= 4'h0;
			half_reg <= 6'h00;
			sclk_reg <= 1'b0;
			trig_reg <= 1'b0;
			self_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				SAR_HOST_IDLE:
				begin
					self_reg <= i_self_clocked;
					sclk_reg <= i_self_clocked;
					if (i_start && fifo_in_ready)
					begin
						trig_reg <= 1'b1;
						cnt_reg <= 8'h00;
						state_reg <= SAR_HOST_TRIG;
					end
				end
				SAR_HOST_TRIG:
				begin
					if (cnt_reg == `SAR_TRIG_HIGH - 8'h01)
					begin
						trig_reg <= 1'b0;
						cnt_reg <= 8'h00;
						state_reg <= SAR_HOST_WAIT;
					end
					else
					begin
						cnt_reg <= cnt_reg + 8'h01;
					end
				end
				SAR_HOST_WAIT:
				begin
					if (cnt_reg == i_msb_wait)
					begin
						div_reg <= 4'h0;
						half_reg <= 6'h00;
						state_reg <= SAR_HOST_BURST;
					end
					else
					begin
						cnt_reg <= cnt_reg + 8'h01;
					end
				end
				SAR_HOST_BURST:
				begin
					if (div_reg == `SAR_HALF_PERIOD - 4'h1)
					begin
						div_reg <= 4'h0;
						sclk_reg <= ~sclk_reg;
						half_reg <= half_reg + 6'h01;
						if (half_reg == halves - 6'h01)
						begin
							cnt_reg <= 8'h00;
							state_reg <= SAR_HOST_DRAIN;
						end
					end
					else
					begin
						div_reg <= div_reg + 4'h1;
					end
				end
				SAR_HOST_DRAIN:
				begin
					if (cnt_reg == `SAR_DRAIN_CYC)
					begin
						state_reg <= SAR_HOST_PUSH;
					end
					else
					begin
						cnt_reg <= cnt_reg + 8'h01;
					end
				end
				SAR_HOST_PUSH:
				begin
					state_reg <= SAR_HOST_IDLE;
				end
				default:
				begin
					state_reg <= SAR_HOST_IDLE;
				end
			endcase
		end
	end

	// Self mode samples a fixed lag after each own rising edge
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			rise_pipe_reg <= '0;
		end
		else
		begin
			rise_pipe_reg <= {rise_pipe_reg[`SAR_CAPTURE_LAG-2:0],
				(state_reg == SAR_HOST_BURST) && (div_reg == `SAR_HALF_PERIOD - 4'h1) && !sclk_reg};
		end
	end

	assign cap_strobe = self_reg ? rise_pipe_reg[`SAR_CAPTURE_LAG-1] : (sync2_reg[1] & ~sync3_reg[1]);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			cap_reg <= 18'h00000;
			bits_reg <= 5'h00;
		end
		else if (state_reg == SAR_HOST_IDLE)
		begin
			bits_reg <= 5'h00;
		end
		else if (cap_strobe && (bits_reg < bits_want))
		begin
			cap_reg <= {cap_reg[16:0], sync2_reg[0]};
			bits_reg <= bits_reg + 5'h01;
		end
	end

	// Self mode frame must carry the 1 then 0 of the header
	assign frame_ok = (bits_reg == bits_want) && (!self_reg || ({1'b0, cap_reg[17:16]} == `SAR_HEADER));

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			err_reg <= 1'b0;
			sel_up_reg <= 1'b1;
			sel_lo_reg <= 1'b1;
		end
		else
		begin
			err_reg <= (state_reg == SAR_HOST_PUSH) && !frame_ok;
			sel_up_reg <= i_sel_upper;
			sel_lo_reg <= i_sel_lower;
		end
	end

	sar_fifo #(
		.WIDTH(`SAR_WORD_W),
		.DEPTH(`SAR_FIFO_DEPTH)
	) u_fifo (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_in_valid((state_reg == SAR_HOST_PUSH) && frame_ok),
		.o_in_ready(fifo_in_ready),
		.i_in_data(cap_reg[15:0]),
		.o_out_valid(o_word_valid),
		.i_out_ready(i_word_ready),
		.o_out_data(o_word_data)
	);

	assign o_start_ready = (state_reg == SAR_HOST_IDLE) && fifo_in_ready;
	assign o_busy = (state_reg != SAR_HOST_IDLE);
	assign o_frame_err = err_reg;
	assign link.sample_trigger = trig_reg;
	assign link.shift_clock = sclk_reg;
	assign link.echo_tie_low = self_reg;
	assign link.source_sel_upper = sel_up_reg;
	assign link.source_sel_lower = sel_lo_reg;
endmodule : sar_adc_host

/* sar_defines.svh */
// Shared constants for the converter readout link
// Behaviour
// - Trigger rise starts conversion, holds sample
// - Sixteen weighted steps decide bits, MSB first
// - Result readable after first-bit delay only
// - Host bursts shift clock, one bit each
// - Shift clock steady from cutoff to first-bit
// - Two read modes: echoed-clock and self-clocked
// - Echo pin grounded selects self-clocked mode
// - Sixteen-bit twos complement word, MSB first
// - Zero maps 0x0000, limits 0x7fff and 0x8000
// - Select pins choose the reference source
// - Both select pins low powers down
// - Select pins strapped or driven by host
// - Trigger single-ended or differential from host
// - Echo mode: 16 pulses, clock idles low
// - Self mode: 010 header before each word
// - Self mode: 18 pulses, clock idles high
// - Triggers during conversion are ignored
`ifndef SAR_DEFINES_SVH
`define SAR_DEFINES_SVH

`define SAR_CLK_NS 8
`define SAR_MSB_DELAY_NS 200
`define SAR_MSB_CYC ((`SAR_MSB_DELAY_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CUTOFF_NS 150
`define SAR_CUTOFF_CYC (`SAR_CUTOFF_NS / `SAR_CLK_NS)
`define SAR_BITS 16
`define SAR_WORD_W 16
`define SAR_SIGN_FLIP 16'h8000
`define SAR_POS_LIMIT 17'sh07fff
`define SAR_NEG_LIMIT (-17'sh08000)
`define SAR_FULL_WEIGHT 17'h10000
`define SAR_HEADER 3'h2
`define SAR_STRAP_CYC 3'h4
`define SAR_ECHO_HALVES 6'h20
`define SAR_SELF_HALVES 6'h24
`define SAR_ECHO_BITS 5'h10
`define SAR_SELF_BITS 5'h12
`define SAR_HALF_PERIOD 4'h5
`define SAR_TRIG_HIGH 8'h03
`define SAR_DRAIN_CYC 8'h10
`define SAR_CAPTURE_LAG 4
`define SAR_FIFO_DEPTH 32

`endif

/* sar_pkg.sv */
// Types shared by both ends of the converter link
package sar_pkg;
	typedef enum logic [1:0] {
		SAR_REF_OFF = 2'b00,
		SAR_REF_EXT_LOW = 2'b01,
		SAR_REF_EXT_HIGH = 2'b10,
		SAR_REF_INTERNAL = 2'b11
	} sar_ref_mode_t;

	typedef enum logic {
		SAR_DEV_ACQ = 1'b0,
		SAR_DEV_CONV = 1'b1
	} sar_dev_state_t;

	typedef enum logic [2:0] {
		SAR_HOST_IDLE = 3'b000,
		SAR_HOST_TRIG = 3'b001,
		SAR_HOST_WAIT = 3'b010,
		SAR_HOST_BURST = 3'b011,
		SAR_HOST_DRAIN = 3'b100,
		SAR_HOST_PUSH = 3'b101
	} sar_host_state_t;
endpackage : sar_pkg

/* sar_link_if.sv */
// Pin-level link between converter and host
`timescale 1ns/1ps
interface sar_link_if;
	logic sample_trigger;
	logic shift_clock;
	logic serial_data;
	logic echoed_clock_o;
	logic echoed_clock_oe;
	logic echo_tie_low;
	logic source_sel_upper;
	logic source_sel_lower;
	logic echoed_clock_out;

	// Undriven echo pin reads low when grounded, else pulled high
	assign echoed_clock_out = echoed_clock_oe ? echoed_clock_o : ~echo_tie_low;

	modport dev (
		input sample_trigger,
		input shift_clock,
		input echoed_clock_out,
		input source_sel_upper,
		input source_sel_lower,
		output serial_data,
		output echoed_clock_o,
		output echoed_clock_oe
	);

	modport host (
		output sample_trigger,
		output shift_clock,
		output echo_tie_low,
		output source_sel_upper,
		output source_sel_lower,
		input serial_data,
		input echoed_clock_out
	);
endinterface : sar_link_if

/* sar_adc_device.sv */
// Converter end: conversion control, approximation and serial readout
`timescale 1ns/1ps
`include "sar_defines.svh"
module sar_adc_device (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Input difference in code steps, clipped to range
	input wire logic signed [16:0] i_input_diff,
	// Link to host
	sar_link_if.dev link,
	// Status
	output sar_pkg::sar_ref_mode_t o_ref_mode,
	output logic o_power_down,
	output logic o_self_clocked,
	output logic o_busy
);
	import sar_pkg::*;

	// Clip the difference and turn it into offset binary
	function automatic logic [15:0] sar_offset_code(input logic signed [16:0] diff);
		logic signed [16:0] lim;
		lim = diff;
		if (diff > `SAR_POS_LIMIT)
		begin
			lim = `SAR_POS_LIMIT;
		end
		else if (diff < `SAR_NEG_LIMIT)
		begin
			lim = `SAR_NEG_LIMIT;
		end
		return lim[15:0] ^ `SAR_SIGN_FLIP;
	endfunction : sar_offset_code

	// Weight of the bit decided at a given step, step 1 is the MSB
	function automatic logic [15:0] sar_weight(input logic [7:0] step);
		return 16'(`SAR_FULL_WEIGHT >> step);
	endfunction : sar_weight

	// Pin synchronisers: bit 0 trigger, 1 shift clock, 2 echo pin, 3 upper, 4 lower
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [4:0] sync3_reg;
	logic trig_rise;
	logic sclk_fall;

	sar_ref_mode_t ref_reg;
	logic [2:0] strap_cnt_reg;
	logic strap_done_reg;
	logic self_reg;

	sar_dev_state_t state_reg;
	logic [7:0] timer_reg;
	logic [15:0] held_reg;
	logic [15:0] approx_reg;
	logic [15:0] trial;
	logic start;

	logic read_active_reg;
	logic [18:0] shift_reg;
	logic data_reg;
	logic echo_reg;
	logic echo_oe_reg;

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			sync1_reg <= 5'h00;
			sync2_reg <= 5'h00;
			sync3_reg <= 5'h00;
		end
		else
		begin
			sync1_reg <= {link.source_sel_lower, link.source_sel_upper, link.echoed_clock_out,
				link.shift_clock, link.sample_trigger};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign trig_rise = sync2_reg[0] & ~sync3_reg[0];
	assign sclk_fall = ~sync2_reg[1] & sync3_reg[1];

	// Reference source follows the two select pins
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			ref_reg <= SAR_REF_OFF;
		end
		else
		begin
			ref_reg <= sar_ref_mode_t'({sync2_reg[3], sync2_reg[4]});
		end
	end

	// Read mode strap: echo pin left undriven, then sampled once
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			strap_cnt_reg <= 3'h0;
			strap_done_reg <= 1'b0;
			self_reg <= 1'b0;
		end
		else if (!strap_done_reg)
		begin
			strap_cnt_reg <= strap_cnt_reg + 3'h1;
			if (strap_cnt_reg == `SAR_STRAP_CYC)
			begin
				strap_done_reg <= 1'b1;
				self_reg <= ~sync2_reg[2];
			end
		end
	end

	// Conversion may start only when idle, strapped and powered
	assign start = (state_reg == SAR_DEV_ACQ) && trig_rise && strap_done_reg && (ref_reg != SAR_REF_OFF);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_reg <= SAR_DEV_ACQ;
			timer_reg <= 8'h00;
			held_reg <= 16'h0000;
		end
		else
		begin
			case (state_reg)
				SAR_DEV_ACQ:
				begin
					if (start)
					begin
						held_reg <= sar_offset_code(i_input_diff);
						timer_reg <= 8'h01;
						state_reg <= SAR_DEV_CONV;
					end
				end
				SAR_DEV_CONV:
				begin
					// Trigger edges are not looked at here
					if (timer_reg == 8'(`SAR_MSB_CYC))
					begin
						timer_reg <= 8'h00;
						state_reg <= SAR_DEV_ACQ;
					end
					else
					begin
						timer_reg <= timer_reg + 8'h01;
					end
				end
				default:
				begin
					state_reg <= SAR_DEV_ACQ;
				end
			endcase
		end
	end

	// One bit per cycle, MSB first, keep the bit if trial does not overshoot
	assign trial = approx_reg | sar_weight(timer_reg);

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			approx_reg <= 16'h0000;
		end
		else if (start)
		begin
			approx_reg <= 16'h0000;
		end
		else if ((state_reg == SAR_DEV_CONV) && (timer_reg <= 8'(`SAR_BITS)))
		begin
			if (trial <= held_reg)
			begin
				approx_reg <= trial;
			end
		end
	end

	// Readout window: closed at cutoff, reopened with the new word
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			read_active_reg <= 1'b0;
			shift_reg <= 19'h00000;
		end
		else if ((state_reg == SAR_DEV_CONV) && (timer_reg == 8'(`SAR_CUTOFF_CYC)))
		begin
			read_active_reg <= 1'b0;
			shift_reg <= 19'h00000;
		end
		else if ((state_reg == SAR_DEV_CONV) && (timer_reg == 8'(`SAR_MSB_CYC)))
		begin
			read_active_reg <= 1'b1;
			if (self_reg)
			begin
				shift_reg <= {`SAR_HEADER, approx_reg ^ `SAR_SIGN_FLIP};
			end
			else
			begin
				shift_reg <= {approx_reg ^ `SAR_SIGN_FLIP, 3'h0};
			end
		end
		else if (read_active_reg && sclk_fall)
		begin
			shift_reg <= {shift_reg[17:0], 1'b0};
		end
	end

	// Pins: data and echo held low outside the readout window
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			data_reg <= 1'b0;
			echo_reg <= 1'b0;
			echo_oe_reg <= 1'b0;
		end
		else
		begin
			data_reg <= read_active_reg & shift_reg[18];
			echo_reg <= read_active_reg & ~self_reg & sync2_reg[1];
			echo_oe_reg <= strap_done_reg & ~self_reg;
		end
	end

	assign link.serial_data = data_reg;
	assign link.echoed_clock_o = echo_reg;
	assign link.echoed_clock_oe = echo_oe_reg;
	assign o_ref_mode = ref_reg;
	assign o_power_down = (ref_reg == SAR_REF_OFF);
	assign o_self_clocked = self_reg;
	assign o_busy = (state_reg == SAR_DEV_CONV);
endmodule : sar_adc_device

/* sar_link_chk.sv */
// Timing checks on the pins between the converter and host ends
`timescale 1ns/1ps
module sar_link_chk (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Link pins
	input wire logic sample_trigger,
	input wire logic shift_clock,
	input wire logic serial_data,
	input wire logic echoed_clock_o,
	input wire logic echoed_clock_oe,
	input wire logic echo_tie_low,
	input wire logic echoed_clock_out
);
	localparam int MSB_MIN = 28;
	logic [7:0] since_reg;
	logic [4:0] pulse_reg;
	logic [4:0] echo_reg;

	default clocking dc @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	// Cycles since the last trigger rise, saturating
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			since_reg <= 8'hff;
		else if ($rose(sample_trigger))
			since_reg <= 8'h00;
		else if (since_reg != 8'hff)
			since_reg <= since_reg + 8'h01;
	end

	// Shift clock pulses leave the idle level of the mode
	always_ff @(posedge i_clock)
	begin
		if (i_rst || $rose(sample_trigger))
			pulse_reg <= 5'h00;
		else if (echo_tie_low ? $fell(shift_clock) : $rose(shift_clock))
			pulse_reg <= pulse_reg + 5'h01;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst || $rose(sample_trigger))
			echo_reg <= 5'h00;
		else if ($rose(echoed_clock_out))
			echo_reg <= echo_reg + 5'h01;
	end

	sequence s_quiet;
		!serial_data && !(echoed_clock_oe && echoed_clock_o);
	endsequence
	sequence s_header;
		!serial_data ##[1:6] serial_data ##[1:12] !serial_data;
	endsequence

	a_trig_pulse_len: assert property ($rose(sample_trigger) |-> sample_trigger [*3] ##1 !sample_trigger)
		else $error("trigger pulse length wrong");
	a_idle_clock_level: assert property (since_reg == 8'h14 |-> shift_clock == echo_tie_low)
		else $error("shift clock idle level wrong");
	a_clock_steady_wait: assert property ($changed(shift_clock) |-> since_reg >= MSB_MIN)
		else $error("shift clock moved before first bit delay");
	a_self_no_echo: assert property (echo_tie_low |-> !echoed_clock_oe)
		else $error("echo pin driven in self-clocked mode");
	a_cutoff_lines_zero: assert property ($rose(sample_trigger) |-> ##22 s_quiet [*5])
		else $error("data or echo not zero before first bit");
	a_burst_pulse_count: assert property ($rose(sample_trigger) |->
		pulse_reg == 5'h00 || pulse_reg == (echo_tie_low ? 5'h12 : 5'h10))
		else $error("wrong shift clock pulse count");
	a_echo_pulse_count: assert property (!echo_tie_low && $rose(sample_trigger) |->
		echo_reg == 5'h00 || echo_reg == 5'h10)
		else $error("wrong echoed clock pulse count");
	a_header_bits: assert property (echo_tie_low && $fell(shift_clock) && pulse_reg == 5'h00 |-> s_header)
		else $error("header bits wrong");
endmodule : sar_link_chk

/* tb_top.sv */
// Bench joining the converter and host ends over the link
`timescale 1ns/1ps
module tb_top;
	import sar_pkg::*;
	localparam int FIFO_WORDS = 32;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic self_mode = 1'b0;
	logic sel_upper = 1'b1;
	logic sel_lower = 1'b1;
	logic [7:0] msb_wait = 8'h1c;
	logic start = 1'b0;
	logic word_ready = 1'b0;
	logic signed [16:0] input_diff = 17'h00000;
	sar_ref_mode_t ref_mode;
	logic power_down, dev_self, dev_busy, start_ready, host_busy, frame_err, word_valid;
	logic [15:0] word_data;
	int num_errors = 0;
	int checks = 0;
	int frame_errs = 0;
	int bound_vals[8] = '{0, 1, -1, 32767, -32768, -32767, 40000, -40000};
	logic [15:0] exp_q[$];

	sar_link_if link();
	always #4 i_clock = ~i_clock;

	sar_adc_device u_sar_adc_device (.i_clock(i_clock), .i_rst(i_rst), .i_input_diff(input_diff), .link(link),
		.o_ref_mode(ref_mode), .o_power_down(power_down), .o_self_clocked(dev_self), .o_busy(dev_busy));
	sar_adc_host u_sar_adc_host (.i_clock(i_clock), .i_rst(i_rst), .i_self_clocked(self_mode),
		.i_sel_upper(sel_upper), .i_sel_lower(sel_lower), .i_msb_wait(msb_wait), .i_start(start),
		.o_start_ready(start_ready), .o_busy(host_busy), .o_frame_err(frame_err), .o_word_valid(word_valid),
		.i_word_ready(word_ready), .o_word_data(word_data), .link(link));
	sar_link_chk u_sar_link_chk (.i_clock(i_clock), .i_rst(i_rst), .sample_trigger(link.sample_trigger),
		.shift_clock(link.shift_clock), .serial_data(link.serial_data), .echoed_clock_o(link.echoed_clock_o),
		.echoed_clock_oe(link.echoed_clock_oe), .echo_tie_low(link.echo_tie_low),
		.echoed_clock_out(link.echoed_clock_out));

	always @(posedge i_clock)
		if (frame_err === 1'b1)
			frame_errs++;

	task automatic check_val(input string name, input logic [16:0] seen, input logic [16:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check_val

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize

	// Clipped difference read as a twos complement code
	function automatic logic [15:0] code_of(input int v);
		if (v > 32767)
			v = 32767;
		if (v < -32768)
			v = -32768;
		return v[15:0];
	endfunction : code_of

	task automatic convert(input int v, output bit taken);
		int n;
		n = 0;
		taken = 1'b0;
		@(negedge i_clock);
		while (start_ready !== 1'b1 && n < 300)
		begin
			@(negedge i_clock);
			n++;
		end
		if (start_ready === 1'b1)
		begin
			@(posedge i_clock);
			input_diff <= 17'(v);
			start <= 1'b1;
			@(posedge i_clock);
			start <= 1'b0;
			exp_q.push_back(code_of(v));
			taken = 1'b1;
			// The sampled value must not follow later input changes
			repeat (14) @(posedge i_clock);
			input_diff <= 17'($urandom);
			n = 0;
			@(negedge i_clock);
			check_val("dev_busy", 17'(dev_busy), 17'h1);
			while (host_busy !== 1'b0 && n < 600)
			begin
				@(negedge i_clock);
				n++;
			end
			check_val("busy_end", 17'(n < 600), 17'h1);
			check_val("dev_idle", 17'(dev_busy), 17'h0);
		end
	endtask : convert

	// Drain with a randomly stalling reader
	task automatic drain;
		int n;
		n = 0;
		while (exp_q.size() > 0 && n < 2000)
		begin
			@(posedge i_clock);
			word_ready <= 1'($urandom);
			@(negedge i_clock);
			if (word_valid === 1'b1 && word_ready === 1'b1)
				check_val("word", {1'b0, word_data}, {1'b0, exp_q.pop_front()});
			n++;
		end
		@(posedge i_clock);
		word_ready <= 1'b0;
	endtask : drain

	initial
	begin
		bit ok;
		int made;
		void'($urandom(32'hfc7cac0e));
		repeat (10) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (12) @(posedge i_clock);
		for (int m = 0; m < 4; m++)
		begin
			@(posedge i_clock);
			{sel_upper, sel_lower} <= 2'(m + 1);
			repeat (8) @(negedge i_clock);
			check_val("ref_mode", 17'(ref_mode), 17'((m + 1) % 4));
			check_val("power_down", 17'(power_down), 17'(m == 3));
		end
		$display("test reference modes done");
		for (int s = 0; s < 2; s++)
		begin
			@(posedge i_clock);
			i_rst <= 1'b1;
			self_mode <= 1'(s);
			{sel_upper, sel_lower} <= 2'($urandom_range(3, 1));
			msb_wait <= (s == 0) ? 8'h1c : 8'h1c + 8'($urandom_range(12));
			repeat (10) @(posedge i_clock);
			i_rst <= 1'b0;
			repeat (12) @(negedge i_clock);
			check_val("self_clocked", 17'(dev_self), 17'(s));
			check_val("ref_restored", 17'(ref_mode), 17'({sel_upper, sel_lower}));
			made = 0;
			ok = 1'b1;
			while (ok && made < FIFO_WORDS + 2)
			begin
				convert(made < 8 ? bound_vals[made] : int'($urandom_range(65535)) - 32768, ok);
				made += int'(ok);
			end
			check_val("fifo_words", 17'(made), 17'(FIFO_WORDS));
			drain;
			check_val("left_words", 17'(exp_q.size()), 17'h0);
			$display("test read mode %0d done", s);
		end
		check_val("frame_errors", 17'(frame_errs), 17'h0);
		summarize;
	end

	initial
	begin
		#400000;
		num_errors++;
		$display("watchdog expired");
		summarize;
	end
endmodule : tb_top
